/* File: design/ebf_consts.svh */
// Constants for the endpoint buffer and slave FIFO block
// Assumes inclusion by bare name from the design files
`ifndef EBF_CONSTS_SVH
`define EBF_CONSTS_SVH
// ----------------------------------------------------------------
// Processor address map
// ----------------------------------------------------------------
`define EBF_SETUP_LO     16'he6b8
`define EBF_SETUP_HI     16'he6bf
`define EBF_EP0_LO       16'he740
`define EBF_EP0_HI       16'he77f
`define EBF_EP1O_LO      16'he780
`define EBF_EP1O_HI      16'he7bf
`define EBF_EP1I_LO      16'he7c0
`define EBF_EP1I_HI      16'he7ff
`define EBF_BIG_LO       16'hf000
`define EBF_SMALL_BIAS   8'h38
`define EBF_SMALL_DEPTH  200
// ----------------------------------------------------------------
// Buffer geometry and packet sizes
// ----------------------------------------------------------------
`define EBF_NUM_BLOCKS   8
`define EBF_BLK_WORDS    256
`define EBF_NUM_CFG      4'hc
`define EBF_FS_PKT       10'h040
`define EBF_HS_PKT       10'h200
// ----------------------------------------------------------------
// Interface mode field codes
// ----------------------------------------------------------------
`define EBF_IFC_MASTER   2'h2
`define EBF_IFC_SLAVE    2'h3
// ----------------------------------------------------------------
// Clock rates in MHz
// ----------------------------------------------------------------
`define EBF_CORE_MHZ     10
`define EBF_INTERFACE_CLOCK_LO_MHZ 30
`define EBF_INTERFACE_CLOCK_HI_MHZ 48
`endif

/* File: design/ebf_pkg.sv */
// Types shared by the endpoint buffer block
// Assumes nothing of its surroundings
package ebf_pkg;
  typedef enum logic [1:0] {EBF_PORT, EBF_MASTER, EBF_SLAVE} ebf_mode_e;
  typedef enum logic [2:0] {
    EBF_R_NONE, EBF_R_SETUP, EBF_R_EP0, EBF_R_EP1O, EBF_R_EP1I, EBF_R_BIG
  } ebf_region_e;
  typedef enum logic [1:0] {EBF_OFF, EBF_BULK, EBF_INT, EBF_ISO} ebf_xfer_e;
  typedef logic [15:0] ebf_addr_t;
  typedef logic [9:0]  ebf_len_t;
endpackage : ebf_pkg

/* File: design/ebf_ram_block.sv */
// One 256 x 16 endpoint RAM block with two byte-enabled ports
// Assumes the caller keeps the two ports off the same word
`timescale 1ns/1ps
module ebf_ram_block #(
  parameter int WORDS = 256
) (
  input  wire logic                     clk,
  input  wire logic                     ce,
  input  wire logic                     a_en,
  input  wire logic                     a_we,
  input  wire logic [1:0]               a_be,
  input  wire logic [$clog2(WORDS)-1:0] a_addr,
  input  wire logic [15:0]              a_wdata,
  output logic      [15:0]              a_q,
  input  wire logic                     b_en,
  input  wire logic                     b_we,
  input  wire logic [1:0]               b_be,
  input  wire logic [$clog2(WORDS)-1:0] b_addr,
  input  wire logic [15:0]              b_wdata,
  output logic      [15:0]              b_q
);
  logic [15:0] mem [WORDS];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Byte-lane writes and registered reads on both ports
  always_ff @(posedge clk) begin
    if (ce) begin
      for (int l = 0; l < 2; l++) begin
        if (a_en && a_we && a_be[l]) mem[a_addr][l*8 +: 8] <= a_wdata[l*8 +: 8];
        if (b_en && b_we && b_be[l]) mem[b_addr][l*8 +: 8] <= b_wdata[l*8 +: 8];
      end
      if (a_en) a_q <= mem[a_addr];
      if (b_en) b_q <= mem[b_addr];
    end
  end
endmodule : ebf_ram_block

/* File: design/ebf_strobe_edge.sv */
// Rising-edge finder for the slave strobes
// Assumes strobe levels synchronous to the clock
`timescale 1ns/1ps
module ebf_strobe_edge #(
  parameter int N = 3
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [N-1:0] lvl,
  output logic      [N-1:0] rise
);
  logic [N-1:0] prev;
  logic [N-1:0] next_prev;

  // ----------------------------------------------------------------
  // Edge detect
  // ----------------------------------------------------------------
  // One pulse per low-to-high edge
  always_comb begin
    next_prev = lvl;
    rise      = lvl & ~prev;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) prev <= '0;
    else if (ce) prev <= next_prev;
  end
endmodule : ebf_strobe_edge

/* File: design/ebf_top.sv */
// Endpoint buffer RAM with slave and master FIFO access
// Assumes a USB engine and a processor on the two byte agent ports
// What this block does
// - Endpoint zero: one shared 64-byte buffer
// - Endpoint one: separate 64-byte in/out buffers
// - Eight 512-byte blocks for endpoints two-eight
// - Four/eight double; two/six double, triple, quad
// - One of twelve block allocations
// - Full speed uses first 64 bytes only
// - Setup bytes at e6b8 to e6bf
// - Large blocks mapped at f000 to ffff
// - Full-speed alternate settings table
// - High-speed alternate settings table
// - Large blocks serve directly as FIFOs
// - Blocks split between USB and I/O
// - Ownership switches without copying bytes
// - USB single port, I/O dual port
// - Master mode drives FIFO select address
// - Master mode runs from core clock
// - Slave mode samples strobes on core clock; derived interface clock is only driven out
// - Byte or word width per endpoint
// - Each strobe edge is one access
// - Strobes ignored without slave select
// - Two-bit field picks interface mode
// - Clock rate select and inversion bits
`timescale 1ns/1ps
`include "ebf_consts.svh"
module ebf_top #(
  parameter int NBLK     = `EBF_NUM_BLOCKS,
  parameter int CORE_MHZ = `EBF_CORE_MHZ
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                ce,
  input  wire logic [1:0]          interface_config,
  input  wire logic                interface_clock_sel_48,
  input  wire logic                interface_clock_invert,
  output logic                     interface_clock,
  input  wire logic                full_speed,
  input  wire logic [1:0]          alt_setting,
  output ebf_pkg::ebf_xfer_e       ep1_type,
  output ebf_pkg::ebf_xfer_e       ep26_type,
  output ebf_pkg::ebf_len_t        ep1_size,
  output ebf_pkg::ebf_len_t        ep_size,
  input  wire logic [3:0]          buf_config,
  input  wire logic [3:0]          ep_dir_in,
  input  wire logic [3:0]          ep_word,
  input  wire logic [NBLK-1:0]     usb_give_io,
  input  wire logic [9:0]          usb_give_len,
  output logic      [NBLK-1:0]     usb_owner_io,
  output logic      [NBLK-1:0]     io_handback,
  output logic      [9:0]          commit_len,
  input  wire logic                usb_en,
  input  wire logic                usb_we,
  input  wire ebf_pkg::ebf_addr_t  usb_addr,
  input  wire logic [7:0]          usb_wdata,
  output logic      [7:0]          usb_rdata,
  input  wire logic                cpu_en,
  input  wire logic                cpu_we,
  input  wire ebf_pkg::ebf_addr_t  cpu_addr,
  input  wire logic [7:0]          cpu_wdata,
  output logic      [7:0]          cpu_rdata,
  input  wire logic                slave_select_n,
  input  wire logic                slave_read_strobe,
  input  wire logic                slave_write_strobe,
  input  wire logic                slave_output_enable,
  input  wire logic                packet_commit,
  input  wire logic [1:0]          fifo_select_address_in,
  output logic      [1:0]          fifo_select_address_out,
  output logic                     fifo_select_address_oe,
  input  wire logic [15:0]         fifo_data_in,
  output logic      [15:0]         fifo_data_out,
  output logic      [1:0]          fifo_data_oe,
  output logic                     fifo_empty,
  output logic                     fifo_full,
  input  wire logic [1:0]          engine_fifo_addr,
  input  wire logic                engine_rd,
  input  wire logic                engine_wr,
  input  wire logic                engine_commit,
  input  wire logic                engine_drive,
  input  wire logic [1:0]          ready_in,
  output logic      [1:0]          engine_ready
);
  import ebf_pkg::*;

  // ----------------------------------------------------------------
  // Constants and allocation table
  // ----------------------------------------------------------------
  localparam int H30 = CORE_MHZ / (2 * `EBF_INTERFACE_CLOCK_LO_MHZ);
  localparam int H48 = CORE_MHZ / (2 * `EBF_INTERFACE_CLOCK_HI_MHZ);
  localparam logic [3:0] HALF30 = 4'((H30 < 1) ? 1 : H30);
  localparam logic [3:0] HALF48 = 4'((H48 < 1) ? 1 : H48);
  // Block counts per endpoint two, four, six, eight (one nibble each)
  localparam logic [15:0] CFG_TABLE [12] = '{
    16'h2222, 16'h2240, 16'h4022, 16'h4040, 16'h3032, 16'h3230,
    16'h2042, 16'h4220, 16'h2022, 16'h4020, 16'h2040, 16'h3040};

  function automatic ebf_region_e region_of(input ebf_addr_t a);
    ebf_region_e r;
    r = EBF_R_NONE;
    if (a >= `EBF_SETUP_LO && a <= `EBF_SETUP_HI) r = EBF_R_SETUP;
    else if (a >= `EBF_EP0_LO && a <= `EBF_EP0_HI) r = EBF_R_EP0;
    else if (a >= `EBF_EP1O_LO && a <= `EBF_EP1O_HI) r = EBF_R_EP1O;
    else if (a >= `EBF_EP1I_LO && a <= `EBF_EP1I_HI) r = EBF_R_EP1I;
    else if (a >= `EBF_BIG_LO) r = EBF_R_BIG;
    return r;
  endfunction : region_of

  ebf_mode_e   mode;
  logic [3:0]  cnt [4];
  logic [3:0]  base [4];
  logic [15:0] cfg;
  logic [1:0]  sel;
  logic        rd_req, wr_req, cmt_req, oe_req;
  logic [2:0]  rise;
  logic [1:0]  cur [4], next_cur [4];
  ebf_len_t    pos [4], next_pos [4];
  ebf_len_t    blk_len [NBLK], next_len [NBLK];
  logic [NBLK-1:0] owner_io, next_owner, next_hand;
  ebf_len_t    next_clen, pkt, step, cur_pos, pos_adv;
  logic [2:0]  cur_blk;
  logic        live, wr_ok, rd_ok, cmt_ok, close;
  logic [15:0] a_q [NBLK];
  logic [15:0] b_q [NBLK];

  // ----------------------------------------------------------------
  // Mode and strobe selection
  // ----------------------------------------------------------------
  // mode field decode
  always_comb begin
    if (interface_config == `EBF_IFC_SLAVE) mode = EBF_SLAVE;
    else if (interface_config == `EBF_IFC_MASTER) mode = EBF_MASTER;
    else mode = EBF_PORT;
  end

  ebf_strobe_edge #(.N(3)) u_edge (
    .clk    (core_clk),
    .resetn (resetn),
    .ce     (ce),
    .lvl    ({packet_commit, slave_write_strobe, slave_read_strobe}),
    .rise   (rise)
  );

  always_comb begin
    sel = 2'h0; rd_req = 1'b0; wr_req = 1'b0; cmt_req = 1'b0; oe_req = 1'b0;
    if (mode == EBF_SLAVE) begin
      sel     = fifo_select_address_in;
      rd_req  = rise[0] & ~slave_select_n;
      wr_req  = rise[1] & ~slave_select_n;
      cmt_req = rise[2] & ~slave_select_n;
      oe_req  = slave_output_enable & ~slave_select_n;
    end else if (mode == EBF_MASTER) begin
      sel     = engine_fifo_addr;
      rd_req  = engine_rd;
      wr_req  = engine_wr;
      cmt_req = engine_commit;
      oe_req  = engine_drive;
    end
  end

  // ----------------------------------------------------------------
  // Allocation and FIFO pointers
  // ----------------------------------------------------------------
  // one of twelve layouts
  always_comb begin
    cfg = CFG_TABLE[(buf_config < `EBF_NUM_CFG) ? buf_config : 4'h0];
    for (int e = 0; e < 4; e++) cnt[e] = cfg[(3-e)*4 +: 4];
    base[0] = 4'h0;
    for (int e = 1; e < 4; e++) base[e] = base[e-1] + cnt[e-1];
  end

  always_comb begin
    pkt        = full_speed ? `EBF_FS_PKT : `EBF_HS_PKT;
    step       = ep_word[sel] ? 10'h002 : 10'h001;
    cur_pos    = pos[sel];
    cur_blk    = 3'(base[sel] + {2'h0, cur[sel]});
    live       = (cnt[sel] != 4'h0) && (mode != EBF_PORT);
    fifo_full  = !live || !ep_dir_in[sel] || !owner_io[cur_blk];
    fifo_empty = !live || ep_dir_in[sel] || !owner_io[cur_blk]
                 || (cur_pos >= blk_len[cur_blk]);
    wr_ok      = ce && wr_req && !fifo_full;
    rd_ok      = ce && rd_req && !fifo_empty;
    cmt_ok     = ce && cmt_req && !fifo_full;
    pos_adv    = cur_pos + ((wr_ok || rd_ok) ? step : 10'h000);
    close      = cmt_ok || (wr_ok && pos_adv >= pkt)
                 || (rd_ok && pos_adv >= blk_len[cur_blk]);
  end

  always_comb begin
    next_cur   = cur;
    next_pos   = pos;
    next_len   = blk_len;
    next_owner = owner_io;
    next_hand  = '0;
    next_clen  = commit_len;
    if (wr_ok || rd_ok) next_pos[sel] = pos_adv;
    if (close) begin
      next_pos[sel] = 10'h000;
      next_cur[sel] = ({2'h0, cur[sel]} + 4'h1 >= cnt[sel]) ? 2'h0
                      : cur[sel] + 2'h1;
      next_owner[cur_blk] = 1'b0;
      next_hand[cur_blk]  = 1'b1;
      next_clen = pos_adv;
      if (ep_dir_in[sel]) next_len[cur_blk] = pos_adv;
    end
    // A give in the same cycle as a hand-back wins
    for (int b = 0; b < NBLK; b++) begin
      if (usb_give_io[b]) begin
        next_owner[b] = 1'b1;
        next_len[b]   = usb_give_len;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int e = 0; e < 4; e++) begin
        cur[e] <= 2'h0;
        pos[e] <= 10'h000;
      end
      for (int b = 0; b < NBLK; b++) blk_len[b] <= 10'h000;
      owner_io    <= '0;
      io_handback <= '0;
      commit_len  <= 10'h000;
    end else if (ce) begin
      cur         <= next_cur;
      pos         <= next_pos;
      blk_len     <= next_len;
      owner_io    <= next_owner;
      io_handback <= next_hand;
      commit_len  <= next_clen;
    end
  end
  assign usb_owner_io = owner_io;

  // ----------------------------------------------------------------
  // Agent ports and RAM blocks
  // ----------------------------------------------------------------
  ebf_addr_t   ag_addr [2];
  ebf_region_e ag_reg [2], rd_reg [2], next_rd_reg [2];
  logic        ag_en [2], ag_we [2];
  logic [7:0]  ag_wdata [2], ag_idx [2], small_q [2], rdata [2];
  logic [2:0]  rd_blk [2], next_rd_blk [2];
  logic        rd_lane [2], next_rd_lane [2];
  logic [7:0]  small_mem [`EBF_SMALL_DEPTH];

  // Agent zero is the USB engine, agent one the processor
  // shared small buffer for setup, endpoint zero and endpoint one bytes
  always_comb begin
    ag_addr  = '{usb_addr, cpu_addr};
    ag_en    = '{usb_en, cpu_en};
    ag_we    = '{usb_we, cpu_we};
    ag_wdata = '{usb_wdata, cpu_wdata};
    for (int k = 0; k < 2; k++) begin
      ag_reg[k] = region_of(ag_addr[k]);
      ag_idx[k] = (ag_reg[k] == EBF_R_SETUP) ? {5'h00, ag_addr[k][2:0]}
                  : ag_addr[k][7:0] - `EBF_SMALL_BIAS;
      next_rd_reg[k]  = ag_en[k] ? ag_reg[k] : EBF_R_NONE;
      next_rd_blk[k]  = ag_addr[k][11:9];
      next_rd_lane[k] = ag_addr[k][0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce) begin
      for (int k = 1; k >= 0; k--) begin
        if (ag_en[k] && ag_we[k] && ag_reg[k] != EBF_R_NONE
            && ag_reg[k] != EBF_R_BIG) small_mem[ag_idx[k]] <= ag_wdata[k];
        small_q[k] <= small_mem[ag_idx[k]];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_reg  <= '{EBF_R_NONE, EBF_R_NONE};
      rd_blk  <= '{3'h0, 3'h0};
      rd_lane <= '{1'b0, 1'b0};
    end else if (ce) begin
      rd_reg  <= next_rd_reg;
      rd_blk  <= next_rd_blk;
      rd_lane <= next_rd_lane;
    end
  end

  // Read data of each agent from the region it addressed
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      if (rd_reg[k] == EBF_R_BIG)
        rdata[k] = rd_lane[k] ? a_q[rd_blk[k]][15:8] : a_q[rd_blk[k]][7:0];
      else if (rd_reg[k] == EBF_R_NONE) rdata[k] = 8'h00;
      else rdata[k] = small_q[k];
    end
  end
  assign usb_rdata = rdata[0];
  assign cpu_rdata = rdata[1];

  for (genvar gi = 0; gi < NBLK; gi++) begin : g_blk
    logic s;
    logic a_en, b_en;
    assign s    = owner_io[gi];
    assign a_en = ag_en[s] && ag_reg[s] == EBF_R_BIG
                  && ag_addr[s][11:9] == 3'(gi);
    assign b_en = owner_io[gi] && cur_blk == 3'(gi) && live;
    ebf_ram_block #(.WORDS(`EBF_BLK_WORDS)) u_ram (
      .clk     (core_clk),
      .ce      (ce),
      .a_en    (a_en),
      .a_we    (ag_we[s]),
      .a_be    (ag_addr[s][0] ? 2'b10 : 2'b01),
      .a_addr  (ag_addr[s][8:1]),
      .a_wdata ({2{ag_wdata[s]}}),
      .a_q     (a_q[gi]),
      .b_en    (b_en),
      .b_we    (wr_ok),
      .b_be    (ep_word[sel] ? 2'b11 : (cur_pos[0] ? 2'b10 : 2'b01)),
      .b_addr  (cur_pos[8:1]),
      .b_wdata (ep_word[sel] ? fifo_data_in : {2{fifo_data_in[7:0]}}),
      .b_q     (b_q[gi])
    );
  end

  // ----------------------------------------------------------------
  // Output registers and interface clock
  // ----------------------------------------------------------------
  logic [15:0] next_dout;
  logic [3:0]  ifc_cnt, next_ifc_cnt, half;
  logic        ifc, next_ifc;
  ebf_xfer_e   next_t1, next_t26;
  ebf_len_t    next_s1, next_s;

  always_comb begin
    next_dout = ep_word[sel] ? b_q[cur_blk]
              : {8'h00, cur_pos[0] ? b_q[cur_blk][15:8] : b_q[cur_blk][7:0]};
    fifo_data_oe = {2{oe_req && live}} & {ep_word[sel], 1'b1};
    fifo_select_address_oe = (mode == EBF_MASTER);
    next_t1  = (alt_setting == 2'h0) ? EBF_OFF
             : (alt_setting == 2'h1) ? EBF_BULK : EBF_INT;
    next_t26 = (alt_setting == 2'h0) ? EBF_OFF
             : (alt_setting == 2'h1) ? EBF_BULK
             : (alt_setting == 2'h2) ? EBF_INT : EBF_ISO;
    next_s   = (alt_setting == 2'h0) ? 10'h000 : pkt;
    next_s1  = (alt_setting == 2'h0) ? 10'h000
             : (alt_setting == 2'h1) ? pkt : `EBF_FS_PKT;
    half     = interface_clock_sel_48 ? HALF48 : HALF30;
    next_ifc_cnt = (ifc_cnt + 4'h1 >= half) ? 4'h0 : ifc_cnt + 4'h1;
    next_ifc = (ifc_cnt + 4'h1 >= half) ? ~ifc : ifc;
    interface_clock = ifc ^ interface_clock_invert;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_data_out <= 16'h0000;
      fifo_select_address_out <= 2'h0;
      engine_ready  <= 2'h0;
      ep1_type <= EBF_OFF;
      ep26_type <= EBF_OFF;
      ep1_size <= 10'h000;
      ep_size  <= 10'h000;
      ifc_cnt  <= 4'h0;
      ifc      <= 1'b0;
    end else if (ce) begin
      fifo_data_out <= next_dout;
      fifo_select_address_out <= engine_fifo_addr;
      engine_ready  <= ready_in;
      ep1_type <= next_t1;
      ep26_type <= next_t26;
      ep1_size <= next_s1;
      ep_size  <= next_s;
      ifc_cnt  <= next_ifc_cnt;
      ifc      <= next_ifc;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [39:0] pos_flat;
  assign pos_flat = {pos[3], pos[2], pos[1], pos[0]};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_cmt;
    cmt_ok && usb_give_io == '0;
  endsequence
  sequence s_setup_wr;
    usb_en && usb_we && region_of(usb_addr) == EBF_R_SETUP && !cpu_en;
  endsequence

  chk_gate_select: assert property (
    (mode == EBF_SLAVE && slave_select_n) |=> $stable(pos_flat))
    else $error("pointer moved without slave select");
  chk_oe_gated: assert property (
    (mode == EBF_SLAVE && slave_select_n) |-> fifo_data_oe == 2'h0)
    else $error("data driven without slave select");
  chk_oe_width: assert property (
    fifo_data_oe[1] |-> ep_word[sel])
    else $error("upper byte driven in byte mode");
  chk_fs_window: assert property (
    (close && full_speed && ep_dir_in[sel]) |=> commit_len <= `EBF_FS_PKT)
    else $error("full-speed packet above 64 bytes");
  chk_commit_short: assert property (
    s_cmt |=> !usb_owner_io[$past(cur_blk)] && io_handback[$past(cur_blk)])
    else $error("commit did not hand block back");
  chk_one_access: assert property (
    (wr_ok && !close) |=> pos[$past(sel)] == $past(pos_adv))
    else $error("strobe did not advance by one access");
  chk_buf_counts: assert property (
    (cnt[1] inside {4'h0, 4'h2}) && (cnt[3] inside {4'h0, 4'h2})
    && cnt[0] >= 4'h2 && cnt[2] >= 4'h2)
    else $error("illegal buffering depth");
  chk_alloc_fit: assert property (
    base[3] + cnt[3] <= 4'(NBLK))
    else $error("allocation exceeds block count");
  chk_io_owned: assert property (
    (wr_ok || rd_ok) |-> owner_io[cur_blk])
    else $error("FIFO touched a USB-owned block");
  chk_setup_map: assert property (
    s_setup_wr ##1 (!usb_en && !cpu_en) ##1 (usb_en && !usb_we
    && usb_addr == $past(usb_addr, 2) && !cpu_en)
    |=> usb_rdata == $past(usb_wdata, 3))
    else $error("setup byte not returned");
endmodule : ebf_top

/* File: testbench/ebf_far_model.sv */
// Far-side logic model driving the slave FIFO strobes
// Assumes the bench calls pulse from the core clock domain
`timescale 1ns/1ps
module ebf_far_model (
  input  wire logic        clk,
  input  wire logic [15:0] din,
  output logic             sel_n,
  output logic             rd,
  output logic             wr,
  output logic             oe,
  output logic             pc,
  output logic      [15:0] data
);
  logic [15:0] q;
  // Idle: deselected, strobes low
  initial begin
    {sel_n, rd, wr, oe, pc} = 5'h10;
    data = 16'h0000;
    q = 16'h0000;
  end
  // no packet here exceeds 64 bytes
  // one edge per access; k: 0 write, 1 commit, 2 read
  task automatic pulse(input logic s_n, input logic [1:0] k,
                       input logic [15:0] d);
    @(posedge clk);
    sel_n <= s_n;
    data <= d;
    oe <= (k == 2'h2);
    if (k == 2'h1) pc <= 1'b1;
    else if (k == 2'h2) rd <= 1'b1;
    else wr <= 1'b1;
    // Read data settled before the strobe edge
    @(negedge clk);
    q = din;
    repeat (2) @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    oe <= 1'b0;
    pc <= 1'b0;
    data <= ~d; // Released bus shows no stale value
    repeat (2) @(posedge clk);
    sel_n <= 1'b1;
  endtask : pulse
endmodule : ebf_far_model

/* File: testbench/endpoint_buffer_slave_fifo_test.sv */
// Bench for the endpoint buffer block and its slave FIFO port
// Assumes ebf_pkg and the design files are compiled first
`timescale 1ns/1ps
module endpoint_buffer_slave_fifo_test;
  import ebf_pkg::*;
  logic core_clk, resetn, usb_en, usb_we, cpu_en, cpu_we, fs;
  logic full, empty, sn, rd, wr, oe, pc;
  logic [1:0] rdy, eng_rdy, alt, icfg;
  logic [3:0] dir;
  logic [7:0] usb_wd, cpu_wd, usb_rd, cpu_rd, got, give, own, hb;
  logic [9:0] clen, esz;
  logic [15:0] fd, dout;
  logic ce, edrv;
  logic [1:0] fsa, eaddr;
  logic [3:0] bcfg, wrd;
  logic [9:0] glen, s1;
  ebf_addr_t usb_a, cpu_a;
  ebf_xfer_e t26, t1;
  int bad_count, cmp_count, seen;
  ebf_top ebf_top_inst (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .interface_config(icfg), .interface_clock_sel_48(1'b1), .interface_clock_invert(1'b0),
    .interface_clock(), .full_speed(fs), .alt_setting(alt),
    .ep1_type(t1), .ep26_type(t26), .ep1_size(s1), .ep_size(esz),
    .buf_config(bcfg), .ep_dir_in(dir), .ep_word(wrd),
    .usb_give_io(give), .usb_give_len(glen), .usb_owner_io(own),
    .io_handback(hb), .commit_len(clen), .usb_en(usb_en),
    .usb_we(usb_we), .usb_addr(usb_a), .usb_wdata(usb_wd),
    .usb_rdata(usb_rd), .cpu_en(cpu_en), .cpu_we(cpu_we),
    .cpu_addr(cpu_a), .cpu_wdata(cpu_wd), .cpu_rdata(cpu_rd),
    .slave_select_n(sn), .slave_read_strobe(rd),
    .slave_write_strobe(wr), .slave_output_enable(oe),
    .packet_commit(pc), .fifo_select_address_in(fsa),
    .fifo_select_address_out(), .fifo_select_address_oe(),
    .fifo_data_in(fd), .fifo_data_out(dout), .fifo_data_oe(),
    .fifo_empty(empty), .fifo_full(full), .engine_fifo_addr(eaddr),
    .engine_rd(1'b0), .engine_wr(1'b0), .engine_commit(1'b0),
    .engine_drive(edrv), .ready_in(rdy), .engine_ready(eng_rdy));
  ebf_far_model ebf_far_model_inst (.clk(core_clk), .din(dout), .sel_n(sn),
    .rd(rd), .wr(wr), .oe(oe), .pc(pc), .data(fd));
  // Clock and hand-back pulse counter
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (hb[0] === 1'b1) seen++;
  // Compare and verdict
  task automatic chk(input string n, input logic [9:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // One byte-port access; read data lands the cycle after
  task automatic acc(input logic c, we, input ebf_addr_t a,
                     input logic [7:0] d);
    @(posedge core_clk);
    if (c) {cpu_en, cpu_we, cpu_a, cpu_wd} <= {1'b1, we, a, d};
    else {usb_en, usb_we, usb_a, usb_wd} <= {1'b1, we, a, d};
    @(posedge core_clk);
    cpu_en <= 1'b0;
    usb_en <= 1'b0;
    #1 got = c ? cpu_rd : usb_rd;
  endtask : acc
  // Main sequence
  initial begin
    {resetn, usb_en, usb_we, cpu_en, cpu_we, fs} = 6'h00;
    {rdy, alt, icfg, dir, give} = 16'h0000;
    {usb_a, cpu_a, usb_wd, cpu_wd} = 48'h0;
    {ce, edrv, fsa, eaddr, bcfg, wrd, glen} = {1'b1, 23'h0};
    repeat (11) @(posedge core_clk);
    #1 chk("full", 1, full);
    chk("owner", 0, own);
    @(posedge core_clk);
    resetn <= 1'b1;
    acc(0, 1, 16'he6b8, 8'haa);
    acc(0, 0, 16'he6b8, 8'h00);
    chk("setup", 8'haa, got);
    acc(0, 1, 16'he740, 8'h5c);
    acc(1, 0, 16'he740, 8'h00);
    chk("ep0", 8'h5c, got);
    acc(1, 0, 16'he800, 8'h00);
    chk("hole", 0, got);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      {fs, alt, rdy} <= {i[2], i[1:0], i[1:0]};
      repeat (2) @(posedge core_clk);
      #1 chk("type", i[1:0], t26);
      chk("size", (i[1:0] == 2'h0) ? 10'h000
          : i[2] ? 10'h040 : 10'h200, esz);
      chk("ready", i[1:0], eng_rdy);
      chk("ep1 type", (i[1:0] == 2'h0) ? 10'h000
          : (i[1:0] == 2'h1) ? 10'h001 : 10'h002, t1);
      chk("ep1 size", (i[1:0] == 2'h0) ? 10'h000
          : (i[1:0] == 2'h1 && !i[2]) ? 10'h200 : 10'h040, s1);
    end
    @(posedge core_clk);
    {ce, alt} <= {1'b0, 2'h1};
    repeat (2) @(posedge core_clk);
    #1 chk("freeze", 3, t26);
    @(posedge core_clk);
    ce <= 1'b1;
    @(posedge core_clk);
    {icfg, dir, give} <= {2'h3, 4'h1, 8'h01};
    @(posedge core_clk);
    give <= 8'h00;
    repeat (2) @(posedge core_clk);
    #1 chk("owned", 1, own[0]);
    chk("room", 0, full);
    ebf_far_model_inst.pulse(1'b1, 2'h0, 16'h0077);
    ebf_far_model_inst.pulse(1'b0, 2'h0, 16'h0012);
    ebf_far_model_inst.pulse(1'b0, 2'h1, 16'h0000);
    chk("back", 1, seen);
    chk("len", 1, clen);
    chk("usb", 0, own[0]);
    acc(0, 0, 16'hf000, 8'h00);
    chk("data", 8'h12, got);
    // OUT block of endpoint four: USB fills, slave reads
    acc(0, 1, 16'hf400, 8'h3c);
    @(posedge core_clk);
    {fsa, glen, give} <= {2'h1, 10'h001, 8'h04};
    @(posedge core_clk);
    give <= 8'h00;
    repeat (2) @(posedge core_clk);
    #1 chk("filled", 0, empty);
    ebf_far_model_inst.pulse(1'b0, 2'h2, 16'h0000);
    chk("read", 10'h03c, ebf_far_model_inst.q[9:0]);
    chk("out back", 0, own[2]);
    chk("drained", 1, empty);
    report_and_stop();
  end
  // Watchdog
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule : endpoint_buffer_slave_fifo_test
